// [ddrc_capture.sv]
// Purpose: DDR read data capture with host status, control and data ports
// Assumes: clk is twice the memory clock; memory pins are asynchronous
// Notes:   Command, address and write sequencing live elsewhere
//
// Summary of operation
// RQ1 - The data strobe never times capture; it is watched for status only.
// RQ2 - Read data is sampled in the controller's own clock domain.
// RQ3 - Memory drives data and strobe on reads; the controller captures the data.
// RQ4 - Memory launches its strobe edge-aligned with data, not centred.
// RQ5 - Each data beat stays valid for half a memory clock period.
// RQ6 - The 2x system clock samples each beat inside its valid window.
// RQ7 - Two-beat burst: first byte at one sample, second at the next, both registered.
// RQ8 - Host reaches the controller only through its register set.
// RQ9 - Status reports done, data ready and pending interrupts.
// RQ10 - Control holds interrupt enables, divisor, phase, polarity and start/stop.
// RQ11 - Data input register holds host write data bound for the memory.
// RQ12 - Data output register presents bytes read from the memory.
// RQ13 - Read state enables capture and a beat counter for the burst length.
// RQ14 - Data ready is raised for the host as each byte reaches the data output register.
module ddrc_capture
    import ddrc_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_D
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Memory pins
    input  wire logic [DQ_W-1:0]  dq_in,
    output logic      [DQ_W-1:0]  dq_out,
    output logic                  dq_oe,
    input  wire logic             dqs_in,
    output logic                  mem_clk,
    output logic                  mem_clk_n,
    output logic                  read_cmd,
    // Host control register
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [1:0]       int_en,
    input  wire logic [DIV_W-1:0] clk_div,
    input  wire logic             clk_phase,
    input  wire logic             clk_pol,
    input  wire logic [BL_W-1:0]  burst_len,
    input  wire logic [CL_W-1:0]  cas_lat,
    // Host data input register
    input  wire logic             wdata_wr,
    input  wire logic [DQ_W-1:0]  wdata,
    // Host data output register
    input  wire logic             rdata_rd,
    output logic      [DQ_W-1:0]  rdata,
    // Host status register
    input  wire logic             done_clr,
    output logic                  done,
    output logic                  data_ready,
    output logic                  irq_pending,
    output logic                  busy,
    output logic                  strobe_seen
);

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [DQ_W-1:0] dq_s1;
    logic [DQ_W-1:0] dq_s2;
    logic            dqs_s1;
    logic            dqs_s2;

    always_ff @(posedge clk) begin
        dq_s1  <= dq_in;
        dq_s2  <= dq_s1;
        dqs_s1 <= dqs_in;
        dqs_s2 <= dqs_s1;
    end

    // ************************************************
    // Rate divider and memory clock
    // ************************************************
    logic [DIV_W-1:0] div_cnt;
    logic             mclk;
    wire              tick = (div_cnt == clk_div);

    always_ff @(posedge clk) begin
        if (rst || tick) begin
            div_cnt <= DIV_RST;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    ddrc_state_e state;
    ddrc_state_e next_state;

    // Phase only moves while idle so a burst never sees a clock glitch
    always_ff @(posedge clk) begin
        if (rst) begin
            mclk <= 1'b0;
        end else if (state == DDRC_IDLE) begin
            mclk <= clk_phase;
        end else if (tick) begin
            mclk <= ~mclk;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_clk   <= 1'b0;
            mem_clk_n <= 1'b1;
        end else begin
            mem_clk   <= mclk ^ clk_pol;
            mem_clk_n <= ~(mclk ^ clk_pol);
        end
    end

    // ************************************************
    // Read sequencer
    // ************************************************
    logic [CL_W-1:0] cas_cnt;
    logic [BL_W-1:0] beat_cnt;
    logic            fifo_in_ready;
    wire             start_ok = start && fifo_in_ready;
    wire             cas_end  = tick && (cas_cnt >= cas_lat);
    wire             last_bt  = (beat_cnt >= burst_len);
    // Beats advance only when the FIFO can take them
    wire             beat     = (state == DDRC_DATA) && tick && fifo_in_ready;

    always_comb begin
        next_state = state;
        case (state)
            DDRC_IDLE: begin
                if (start_ok) begin
                    next_state = DDRC_CAS;
                end
            end
            DDRC_CAS: begin
                if (cas_end) begin
                    next_state = DDRC_DATA;
                end
            end
            DDRC_DATA: begin
                if (beat && last_bt) begin
                    next_state = DDRC_DONE; // [RQ13]
                end
            end
            DDRC_DONE: begin
                next_state = DDRC_IDLE;
            end
            default: begin
                next_state = DDRC_IDLE;
            end
        endcase
        if (stop) begin
            next_state = DDRC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= DDRC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state != DDRC_CAS) begin
            cas_cnt <= CL_ONE;
        end else if (tick) begin
            cas_cnt <= cas_cnt + CL_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state != DDRC_DATA) begin
            beat_cnt <= BEAT_ONE;
        end else if (beat) begin
            beat_cnt <= beat_cnt + BL_W'(1); // [RQ13]
        end
    end

    // ************************************************
    // Capture path
    // ************************************************
    // Strobe is edge-aligned, so sampling on it would land on transitions
    logic [DQ_W-1:0] cap_byte;
    logic            cap_valid;

    always_ff @(posedge clk) begin
        if (rst) begin
            cap_byte  <= DQ_RST;
            cap_valid <= 1'b0;
        end else begin
            cap_valid <= beat; // [RQ6] [RQ7]
            if (beat) begin
                cap_byte <= dq_s2; // [RQ1] [RQ2] [RQ3]
            end
        end
    end

    logic            fifo_out_valid;
    logic [DQ_W-1:0] fifo_out_data;
    wire             load_out = fifo_out_valid && (!data_ready || rdata_rd);

    ddrc_fifo #(
        .WIDTH(DQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .in_valid (cap_valid),
        .in_ready (fifo_in_ready),
        .in_data  (cap_byte),
        .out_valid(fifo_out_valid),
        .out_ready(load_out),
        .out_data (fifo_out_data)
    );

    // ************************************************
    // Host registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata      <= DQ_RST;
            data_ready <= 1'b0;
        end else if (load_out) begin
            rdata      <= fifo_out_data; // [RQ12] [RQ8]
            data_ready <= 1'b1; // [RQ14]
        end else if (rdata_rd) begin
            data_ready <= 1'b0;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
        end else if (state == DDRC_DONE) begin
            done <= 1'b1; // [RQ9]
        end else if (done_clr) begin
            done <= 1'b0;
        end
    end

    wire irq_next = (done && int_en[IEN_DONE]) || (data_ready && int_en[IEN_READY]);

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_pending <= 1'b0;
            busy        <= 1'b0;
            read_cmd    <= 1'b0;
            strobe_seen <= 1'b0;
        end else begin
            irq_pending <= irq_next; // [RQ9] [RQ10]
            busy        <= (next_state != DDRC_IDLE);
            read_cmd    <= (state == DDRC_IDLE) && start_ok && !stop;
            strobe_seen <= dqs_s2 && (state == DDRC_DATA);
        end
    end

    // Write path is elsewhere; the pins stay released here
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_out <= DQ_RST;
            dq_oe  <= 1'b0;
        end else begin
            dq_oe <= 1'b0;
            if (wdata_wr) begin
                dq_out <= wdata; // [RQ11]
            end
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    property p_capture_value;
        @(posedge clk) disable iff (rst)
        beat |=> (cap_byte == $past(dq_s2)) && cap_valid;
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("capture byte mismatch"); // [RQ2]

    property p_strobe_blind;
        @(posedge clk) disable iff (rst)
        !beat |=> (cap_byte == $past(cap_byte));
    endproperty
    a_strobe_blind: assert property (p_strobe_blind) else $error("capture moved off beat"); // [RQ1]

    property p_beats_on_tick;
        @(posedge clk) disable iff (rst)
        cap_valid |-> $past(tick) && $past(state) == DDRC_DATA;
    endproperty
    a_beats_on_tick: assert property (p_beats_on_tick) else $error("beat off sample point"); // [RQ6]

    property p_two_beats;
        @(posedge clk) disable iff (rst)
        (beat && beat_cnt == BEAT_ONE && burst_len == 4'h2 && clk_div == DIV_RST
            && !stop && fifo_in_ready)
        |=> (state == DDRC_DATA) && (beat_cnt == 4'h2);
    endproperty
    a_two_beats: assert property (p_two_beats) else $error("second byte not pending"); // [RQ7]

    property p_burst_end;
        @(posedge clk) disable iff (rst)
        (beat && last_bt && !stop) |=> state == DDRC_DONE ##1 done;
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("burst did not end"); // [RQ13]

    property p_ready_after_load;
        @(posedge clk) disable iff (rst)
        load_out |=> data_ready && rdata == $past(fifo_out_data);
    endproperty
    a_ready_after_load: assert property (p_ready_after_load) else $error("data ready late"); // [RQ14]

    property p_done_sticky;
        @(posedge clk) disable iff (rst)
        done && !done_clr |=> done;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done dropped"); // [RQ9]

    property p_irq_gate;
        @(posedge clk) disable iff (rst)
        ##1 irq_pending == $past(irq_next);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enables"); // [RQ10]

    property p_rdata_hold;
        @(posedge clk) disable iff (rst)
        data_ready && !rdata_rd |=> $stable(rdata) && data_ready;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("output register changed"); // [RQ12]

    property p_wdata_load;
        @(posedge clk) disable iff (rst)
        wdata_wr |=> dq_out == $past(wdata) && !dq_oe;
    endproperty
    a_wdata_load: assert property (p_wdata_load) else $error("write data not held"); // [RQ11]

endmodule : ddrc_capture

// [ddrc_pkg.sv]
// Purpose: Shared constants and types for the read capture block
// Assumes: clk is the 2x system clock, 10 MHz
// Notes:   Multi-bit reset values and field widths of the capture block live here
package ddrc_pkg;

    // ************************************************
    // Widths and FIFO depth
    // ************************************************
    localparam int DQ_W     = 8;
    localparam int DIV_W    = 4;
    localparam int BL_W     = 4;
    localparam int CL_W     = 3;
    localparam int FIFO_D   = 16;

    // ************************************************
    // Reset values, counts and interrupt enable bit positions
    // ************************************************
    localparam logic [DQ_W-1:0]  DQ_RST   = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RST  = 4'h0;
    localparam logic [BL_W-1:0]  BL_RST   = 4'h0;
    localparam logic [CL_W-1:0]  CL_RST   = 3'h0;
    localparam logic [BL_W-1:0]  BEAT_ONE = 4'h1;
    localparam logic [CL_W-1:0]  CL_ONE   = 3'h1;
    localparam int IEN_DONE  = 0;
    localparam int IEN_READY = 1;

    // ************************************************
    // Sequencer states, Gray along the read path
    // ************************************************
    typedef enum logic [1:0] {
        DDRC_IDLE = 2'b00,
        DDRC_CAS  = 2'b01,
        DDRC_DATA = 2'b11,
        DDRC_DONE = 2'b10
    } ddrc_state_e;

endpackage : ddrc_pkg

// [ddrc_fifo.sv]
// Purpose: Word FIFO between the capture path and the data output register
// Assumes: One clock, synchronous active high reset
// Notes:   Honest full and empty; push refused while full
module ddrc_fifo
    import ddrc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // Count is one bit wider than the pointers so a full FIFO is told from an empty one
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : ddrc_fifo

// [ddrc_mem_model.sv]
// Purpose: Memory side of the read path, answers read_cmd with beats
// Assumes: clk_div is 0, so one beat per system clock
// Notes:   Off-window data inverts every cycle to punish late sampling
module ddrc_mem_model
    import ddrc_pkg::*;
(
    // Clock and control
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            read_cmd,
    input  wire logic            strobe_en,
    input  wire logic [CL_W-1:0] lat,
    // Pins
    output logic      [DQ_W-1:0] dq,
    output logic                 dqs
);
    logic [DQ_W-1:0] beats[$];
    int              t;
    bit              armed;

    initial begin
        dq    = 8'h5A;
        dqs   = 1'b0;
        armed = 0;
    end

    // Strobe flips with each beat, edge-aligned
    // A beat lasts one system clock, half a memory clock
    always @(negedge clk) begin
        if (rst) begin
            armed = 0;
        end else if (read_cmd) begin
            t     = 0;
            armed = 1;
        end else if (armed) begin
            t++;
        end
        if (armed && t >= int'(lat) - 2 && beats.size() > 0) begin
            dq  = beats.pop_front();
            dqs = strobe_en & ~dqs;
        end else begin
            dq  = ~dq;
            dqs = 1'b0;
        end
        if (armed && t >= int'(lat) - 2 && beats.size() == 0) begin
            armed = 0;
        end
    end
endmodule : ddrc_mem_model

// [ddrc_capture_tb.sv]
// Purpose: Self-checking bench for the read capture block
// Assumes: clk_div 0; cas_lat 3 to 7 covers the two-clock pin lag
// Notes:   Expected bytes queue up as the memory model is loaded
module ddrc_capture_tb
    import ddrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst, start, stop, clk_phase, clk_pol, wdata_wr, rdata_rd, done_clr;
    logic strobe_en, dq_oe, dqs_in, mem_clk, mem_clk_n, read_cmd;
    logic done, data_ready, irq_pending, busy, strobe_seen;
    logic [1:0]       int_en;
    logic [DIV_W-1:0] clk_div;
    logic [BL_W-1:0]  burst_len;
    logic [CL_W-1:0]  cas_lat;
    logic [DQ_W-1:0]  dq_in, dq_out, wdata, rdata;
    logic [DQ_W-1:0]  exp_q[$];
    logic [31:0]      lfsr = 32'h6A8D4745;
    int               n_fail = 0;
    int               n_checks = 0;

    ddrc_capture #(.FIFO_DEPTH(16)) uut (.clk(clk), .rst(rst), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .mem_clk(mem_clk),
        .mem_clk_n(mem_clk_n), .read_cmd(read_cmd), .start(start), .stop(stop),
        .int_en(int_en), .clk_div(clk_div), .clk_phase(clk_phase), .clk_pol(clk_pol),
        .burst_len(burst_len), .cas_lat(cas_lat), .wdata_wr(wdata_wr), .wdata(wdata),
        .rdata_rd(rdata_rd), .rdata(rdata), .done_clr(done_clr), .done(done),
        .data_ready(data_ready), .irq_pending(irq_pending), .busy(busy),
        .strobe_seen(strobe_seen));

    ddrc_mem_model mem (.clk(clk), .rst(rst), .read_cmd(read_cmd),
        .strobe_en(strobe_en), .lat(cas_lat), .dq(dq_in), .dqs(dqs_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction : rnd

    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // One read burst; done must land lat+beats+1 clocks after the start edge
    task automatic burst(logic [3:0] bl, logic [2:0] lat);
        int nb, k, rc, mc;
        logic [7:0] b;
        logic pc, ss;
        nb = (bl < 2) ? 1 : int'(bl);
        for (int i = 0; i < nb; i++) begin
            b = rnd();
            mem.beats.push_back(b);
            exp_q.push_back(b);
        end
        b = rnd();
        int_en = b[1:0];
        burst_len = bl;
        cas_lat = lat;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        k = 0;
        rc = int'(read_cmd);
        mc = 0;
        pc = mem_clk;
        ss = 1'b0;
        while (done !== 1'b1 && k < 200) begin
            cyc(1);
            k++;
            rc += int'(read_cmd);
            mc += int'(mem_clk != pc);
            pc = mem_clk;
            ss |= strobe_seen;
        end
        chk("done_time", 8'(k), 8'(lat + nb + 1));
        chk("read_cmd", 8'(rc), 8'h01);
        chk("mclk_toggles", 8'(mc), 8'(lat + nb));
        chk("strobe_seen", 8'(ss), 8'(strobe_en));
        cyc(2);
        chk("busy", busy, 8'h00);
        chk("ready", data_ready, 8'h01);
        chk("irq", irq_pending, |int_en);
        done_clr = 1'b1;
        cyc(1);
        done_clr = 1'b0;
        cyc(1);
        chk("done_clr", done, 8'h00);
    endtask : burst

    task automatic drain(int n);
        int w;
        repeat (n) begin
            w = 0;
            while (data_ready !== 1'b1 && w < 20) begin
                cyc(1);
                w++;
            end
            chk("ready_wait", 8'(w < 20), 8'h01);
            cyc(1);
            chk("rdata", rdata, exp_q.pop_front());
            chk("irq_rdy", irq_pending, int_en[1]);
            rdata_rd = 1'b1;
            cyc(1);
            rdata_rd = 1'b0;
            cyc(3);
        end
        chk("ready_low", data_ready, 8'h00);
    endtask : drain

    // ************************************************
    // Tests
    // ************************************************
    initial begin
        {rst, start, stop, clk_phase, clk_pol, wdata_wr, rdata_rd, done_clr} = '1;
        {start, stop, clk_phase, clk_pol, wdata_wr, rdata_rd, done_clr} = '0;
        strobe_en = 1'b1;
        int_en = 2'h0;
        clk_div = 4'h0;
        burst_len = 4'h2;
        cas_lat = 3'h3;
        wdata = 8'h00;
        cyc(20);
        rst = 1'b0;
        cyc(1);
        chk("rst_done", {done, data_ready, irq_pending, busy}, 8'h00);
        chk("rst_clk", {mem_clk, mem_clk_n, dq_oe, read_cmd}, 8'h04);
        for (int i = 0; i < 4; i++) begin
            {clk_phase, clk_pol} = 2'(i);
            cyc(2);
            chk("clk_idle", {mem_clk, mem_clk_n}, {clk_phase ^ clk_pol, !(clk_phase ^ clk_pol)});
        end
        {clk_phase, clk_pol} = 2'b00;
        wdata = 8'hC3;
        wdata_wr = 1'b1;
        cyc(1);
        wdata_wr = 1'b0;
        cyc(1);
        chk("dq_out", dq_out, 8'hC3);
        chk("dq_oe", dq_oe, 8'h00);
        $display("test regs done");
        burst(4'h2, 3'h3);
        drain(2);
        burst(4'h0, 3'h7);
        drain(1);
        burst(4'h1, 3'h4);
        drain(1);
        repeat (5) begin
            burst(4'(rnd()), 3'(3 + rnd() % 5));
            drain(exp_q.size());
        end
        $display("test bursts done");
        strobe_en = 1'b0;
        burst(4'h2, 3'h5);
        drain(2);
        strobe_en = 1'b1;
        $display("test no strobe done");
        repeat (8) burst(4'h2, 3'h3);
        burst(4'h1, 3'h4);
        start = 1'b1;
        cyc(3);
        chk("refused", {busy, read_cmd}, 8'h00);
        start = 1'b0;
        drain(17);
        $display("test fill done");
        cas_lat = 3'h7;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        cyc(1);
        stop = 1'b1;
        cyc(2);
        chk("stop", {busy, done}, 8'h00);
        stop = 1'b0;
        cyc(12);
        $display("test stop done");
        end_sim();
    end

    initial begin
        #1000000;
        n_fail++;
        end_sim();
    end
endmodule : ddrc_capture_tb
